// ---- rtl/int_pkg.sv ----
package int_pkg;

  // Vector table geometry: 128 word entries, 24-bit addresses
  localparam int NUM_VEC          = 128;
  localparam int VEC_IDX_W        = 7;
  localparam int LVL_W            = 3;
  localparam int ADDR_W           = 24;
  localparam int VBASE_W          = 15;
  localparam int FIRST_MASKABLE   = 4;
  localparam int LAST_MASKABLE    = 117;
  localparam int CFG_SLOTS        = 8;
  localparam int CFG_SEL_W        = 4;

  // Fixed vector offsets inside the table
  localparam logic [8:0] OFS_MACHINE  = 9'h1e8;
  localparam logic [8:0] OFS_SPURIOUS = 9'h1dc;
  localparam logic [8:0] OFS_XREQ     = 9'h1d8;

  // Reset values
  localparam logic [VBASE_W-1:0] VBASE_RST   = 15'h7fff;
  localparam logic [LVL_W-1:0]   LVL_RST     = 3'h1;
  localparam logic [LVL_W-1:0]   LVL_OFF     = 3'h0;
  localparam logic [CFG_SEL_W-1:0] CFG_SEL_RST = 4'h0;

  // APB byte addresses
  localparam logic [7:0] ADDR_VBASE     = 8'h00;
  localparam logic [7:0] ADDR_CFG_SEL   = 8'h04;
  localparam logic [7:0] ADDR_CFG_DATA0 = 8'h08;
  localparam logic [7:0] ADDR_CFG_DATA7 = 8'h24;
  localparam logic [7:0] ADDR_STATUS    = 8'h28;

  // Status register field positions
  localparam int ST_LEVEL_LSB  = 0;
  localparam int ST_WIN_LSB    = 4;
  localparam int ST_FOUND_BIT  = 11;
  localparam int ST_XWAKE_BIT  = 12;
  localparam int ST_LOWPWR_BIT = 13;

  function automatic logic is_cfg_data(input logic [7:0] addr);
    return (addr >= ADDR_CFG_DATA0) && (addr <= ADDR_CFG_DATA7) && (addr[1:0] == 2'h0);
  endfunction : is_cfg_data

  function automatic logic [2:0] cfg_slot(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - ADDR_CFG_DATA0;
    return d[4:2];
  endfunction : cfg_slot

  function automatic logic is_maskable(input int idx);
    return (idx >= FIRST_MASKABLE) && (idx <= LAST_MASKABLE);
  endfunction : is_maskable

endpackage : int_pkg

// ---- rtl/prio_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter
  import int_pkg::*;
(
  // Requests and their levels
  input  wire logic [NUM_VEC-1:0]            req,
  input  wire logic [NUM_VEC-1:0][LVL_W-1:0] levels,
  input  wire logic [LVL_W-1:0]              cur_level,
  // Winner
  output logic                               found,
  output logic      [VEC_IDX_W-1:0]          win_idx,
  output logic      [LVL_W-1:0]              win_level
);

  // Scanning upward with >= lets the higher vector take a tie
  always_comb begin
    found     = 1'b0;
    win_idx   = '0;
    win_level = LVL_OFF;
    for (int i = FIRST_MASKABLE; i <= LAST_MASKABLE; i++) begin
      if (req[i] && (levels[i] != LVL_OFF) && (levels[i] > cur_level)
          && (!found || (levels[i] >= win_level))) begin
        found     = 1'b1;
        win_idx   = VEC_IDX_W'(i);
        win_level = levels[i];
      end
    end
  end

endmodule : prio_arbiter
`default_nettype wire

// ---- rtl/prio_cfg_store.sv ----
`timescale 1ns/1ps
`default_nettype none
module prio_cfg_store
  import int_pkg::*;
(
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // Write side
  input  wire logic                            sel_wr,
  input  wire logic                            data_wr,
  input  wire logic [2:0]                      data_slot,
  input  wire logic [31:0]                     wdata,
  // Stored state
  output logic      [CFG_SEL_W-1:0]            sel_reg,
  output logic      [NUM_VEC-1:0][LVL_W-1:0]   levels
);

  logic [CFG_SEL_W-1:0]          sel_next;
  logic [NUM_VEC-1:0][LVL_W-1:0] lvl_reg;
  logic [NUM_VEC-1:0][LVL_W-1:0] lvl_next;
  logic [VEC_IDX_W-1:0]          wr_idx;

  assign wr_idx = {sel_reg, data_slot};
  assign levels = lvl_reg;

  always_comb begin
    sel_next = sel_reg;
    lvl_next = lvl_reg;
    if (sel_wr) begin
      sel_next = wdata[CFG_SEL_W-1:0];
    end
    // Writes to fixed-priority slots are dropped so they read back as zero
    if (data_wr && is_maskable(int'(wr_idx))) begin
      lvl_next[wr_idx] = wdata[LVL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= CFG_SEL_RST;
      for (int i = 0; i < NUM_VEC; i++) begin
        lvl_reg[i] <= is_maskable(i) ? LVL_RST : LVL_OFF;
      end
    end else begin
      sel_reg <= sel_next;
      lvl_reg <= lvl_next;
    end
  end

endmodule : prio_cfg_store
`default_nettype wire

// ---- rtl/priority_interrupt_wakeup.sv ----
// Function
// - Vector base resets to default, software relocatable
// - Levels set via select and eight data registers
// - Up to seven nested maskable levels
// - Set mask bit blocks maskable preemption
// - Cleared mask allows only higher-level preemption
// - Qualified maskable requests wake from stop/wait
// - Machine exception wakes from stop/wait
// - Set mask bit blocks maskable wake-up
// - Level not above current is ignored
// - X request always wakes, even masked
// - Masked X wake supplies no vector
// - Masked X wake resumes after wait/stop
// - Level zero disables a maskable request
// - Equal levels: higher vector address wins
// - Vector fetch loads winner level into CPU
// - Vanished request yields spurious vector
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_wakeup
  import int_pkg::*;
(
  // APB slave
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Peripheral requests, same clock
  input  wire logic [NUM_VEC-1:0]    irq_req,
  input  wire logic                  machine_exception_req,
  // Non-maskable X request pin, active low
  input  wire logic                  nonmaskable_x_request_n,
  // CPU core state
  input  wire logic                  ccw_i_mask,
  input  wire logic                  ccw_x_mask,
  input  wire logic [LVL_W-1:0]      current_service_level,
  input  wire logic                  low_power,
  input  wire logic                  vector_request,
  // CPU core requests and vectors
  output logic                       maskable_to_cpu,
  output logic                       x_to_cpu,
  output logic                       machine_to_cpu,
  output logic                       vector_valid,
  output logic      [ADDR_W-1:0]     vector_addr,
  output logic                       load_service_level,
  output logic      [LVL_W-1:0]      new_service_level,
  output logic                       resume_next,
  // Clock and power logic
  output logic                       wakeup
);

  // Vector entry address inside the table at the current base
  function automatic logic [ADDR_W-1:0] vec_at(input logic [VBASE_W-1:0] base,
                                               input logic [8:0]         ofs);
    return {base, ofs};
  endfunction : vec_at

  // Every decoded register offset; anything else answers with an error
  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == ADDR_VBASE) || (addr == ADDR_CFG_SEL)
        || is_cfg_data(addr) || (addr == ADDR_STATUS);
  endfunction : is_mapped

  // Configuration storage and arbitration
  logic [CFG_SEL_W-1:0]          cfg_sel;
  logic [NUM_VEC-1:0][LVL_W-1:0] levels;
  logic                          found;
  logic [VEC_IDX_W-1:0]          win_idx;
  logic [LVL_W-1:0]              win_level;
  logic                          wr_access;
  logic                          rd_setup;
  logic                          sel_wr;
  logic                          data_wr;
  logic                          vbase_wr;

  // A write lands only at the access edge, so a stalled master never writes twice
  assign wr_access = psel && penable && pready && pwrite;
  assign rd_setup  = psel && !penable;
  assign sel_wr    = wr_access && (paddr == ADDR_CFG_SEL);
  assign data_wr   = wr_access && is_cfg_data(paddr);
  assign vbase_wr  = wr_access && (paddr == ADDR_VBASE);

  prio_cfg_store u_cfg (
    .pclk      (pclk),
    .presetn   (presetn),
    .sel_wr    (sel_wr),
    .data_wr   (data_wr),
    .data_slot (cfg_slot(paddr)),
    .wdata     (pwdata),
    .sel_reg   (cfg_sel),
    .levels    (levels)
  );

  // The CPU stacks the current level on entry, so the compare alone nests levels 1..7
  prio_arbiter u_arb (
    .req       (irq_req),
    .levels    (levels),
    .cur_level (current_service_level),
    .found     (found),
    .win_idx   (win_idx),
    .win_level (win_level)
  );

  // X pin synchroniser; only the second stage feeds clocked logic
  logic x_meta_reg;
  logic x_sync_reg;
  logic x_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_meta_reg <= 1'b1;
      x_sync_reg <= 1'b1;
    end else begin
      x_meta_reg <= nonmaskable_x_request_n;
      x_sync_reg <= x_meta_reg;
    end
  end

  assign x_active = !x_sync_reg;

  // X qualified for service; a masked X only wakes and resumes
  logic x_unmasked;

  assign x_unmasked = x_active && !ccw_x_mask;

  // Wake path stays combinational: pclk may be stopped in stop mode,
  // so the raw pin is used here and never a synchroniser stage
  logic maskable_qualified;
  logic wake_maskable;
  logic wake_machine;
  logic wake_x;

  assign maskable_qualified = found && !ccw_i_mask;
  // Same qualification as in run mode, so a wake always has a vector to take
  assign wake_maskable      = maskable_qualified;
  assign wake_machine       = machine_exception_req;
  // The X pin wakes even when masked; a glitch costs only a spurious wake
  assign wake_x             = !nonmaskable_x_request_n;

  always_comb begin
    wakeup = low_power && (wake_maskable || wake_machine || wake_x);
  end

  // Register file
  logic [VBASE_W-1:0] vbase_reg;
  logic [VBASE_W-1:0] vbase_next;
  logic [31:0]        prdata_next;
  logic               pready_next;
  logic               pslverr_next;
  logic               mapped;
  logic [31:0]        status_word;
  logic               xwake_reg;
  logic               xwake_next;
  logic               resume_next_d;

  // Unmapped offsets answer with an error and read back zero
  always_comb begin
    mapped = is_mapped(paddr);
  end

  // Live view, taken in the setup cycle like every other read
  always_comb begin
    status_word                          = 32'h0;
    status_word[ST_LEVEL_LSB +: LVL_W]   = current_service_level;
    status_word[ST_WIN_LSB +: VEC_IDX_W] = win_idx;
    status_word[ST_FOUND_BIT]            = found;
    status_word[ST_XWAKE_BIT]            = xwake_reg;
    status_word[ST_LOWPWR_BIT]           = low_power;
  end

  always_comb begin
    vbase_next   = vbase_reg;
    prdata_next  = prdata;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (vbase_wr) begin
      vbase_next = pwdata[ADDR_W-1:9];
    end
    // Answer is prepared in the setup cycle so the access cycle is ready at once
    if (rd_setup) begin
      pready_next  = 1'b1;
      pslverr_next = !mapped;
      prdata_next  = 32'h0;
      if (paddr == ADDR_VBASE) begin
        prdata_next[ADDR_W-1:9] = vbase_reg;
      end else if (paddr == ADDR_CFG_SEL) begin
        prdata_next[CFG_SEL_W-1:0] = cfg_sel;
      end else if (is_cfg_data(paddr)) begin
        prdata_next[LVL_W-1:0] = levels[{cfg_sel, cfg_slot(paddr)}];
      end else if (paddr == ADDR_STATUS) begin
        prdata_next = status_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbase_reg <= VBASE_RST;
      prdata    <= 32'h0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      vbase_reg <= vbase_next;
      prdata    <= prdata_next;
      pready    <= pready_next;
      pslverr   <= pslverr_next;
    end
  end

  // CPU request lines and vector supply
  logic              maskable_next;
  logic              x_next;
  logic              machine_next;
  logic              vvalid_next;
  logic [ADDR_W-1:0] vaddr_next;
  logic              load_next;
  logic [LVL_W-1:0]  level_next;

  always_comb begin
    maskable_next = maskable_qualified;
    x_next        = x_unmasked;
    machine_next  = machine_exception_req;
    vvalid_next   = 1'b0;
    vaddr_next    = vector_addr;
    load_next     = 1'b0;
    level_next    = new_service_level;
    // Vector chosen at fetch time, so a later higher request overrides the first
    if (vector_request) begin
      vvalid_next = 1'b1;
      // Machine and unmasked X outrank every maskable request; a masked X supplies no vector
      if (machine_exception_req) begin
        vaddr_next = vec_at(vbase_reg, OFS_MACHINE);
      end else if (x_unmasked) begin
        vaddr_next = vec_at(vbase_reg, OFS_XREQ);
      end else if (maskable_qualified) begin
        vaddr_next = vec_at(vbase_reg, {win_idx, 2'b00});
        load_next  = 1'b1;
        level_next = win_level;
      end else begin
        vaddr_next = vec_at(vbase_reg, OFS_SPURIOUS);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maskable_to_cpu    <= 1'b0;
      x_to_cpu           <= 1'b0;
      machine_to_cpu     <= 1'b0;
      vector_valid       <= 1'b0;
      vector_addr        <= {VBASE_RST, 9'h000};
      load_service_level <= 1'b0;
      new_service_level  <= LVL_OFF;
    end else begin
      maskable_to_cpu    <= maskable_next;
      x_to_cpu           <= x_next;
      machine_to_cpu     <= machine_next;
      vector_valid       <= vvalid_next;
      vector_addr        <= vaddr_next;
      load_service_level <= load_next;
      new_service_level  <= level_next;
    end
  end

  // Masked X wake: one resume pulse per low-power episode, no vector.
  // Relies on the source holding X until the next instruction runs.

  always_comb begin
    xwake_next    = xwake_reg;
    resume_next_d = 1'b0;
    if (!low_power) begin
      xwake_next = 1'b0;
    end else if (x_active && ccw_x_mask && !xwake_reg) begin
      xwake_next    = 1'b1;
      resume_next_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xwake_reg   <= 1'b0;
      resume_next <= 1'b0;
    end else begin
      xwake_reg   <= xwake_next;
      resume_next <= resume_next_d;
    end
  end

endmodule : priority_interrupt_wakeup
`default_nettype wire

// ---- sim/cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_model
  import int_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Bench control
  input  wire logic             fetch,
  input  wire logic             lvl_set,
  input  wire logic [LVL_W-1:0] lvl_in,
  // Controller side
  input  wire logic             vector_valid,
  input  wire logic             load_service_level,
  input  wire logic [LVL_W-1:0] new_service_level,
  output logic                  vector_request,
  output logic      [LVL_W-1:0] current_service_level
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_request <= 1'b0;
      current_service_level <= '0;
    end else begin
      // Never two requests in a row, as a real core stalls for the answer
      vector_request <= fetch && !vector_request;
      if (lvl_set) begin
        current_service_level <= lvl_in;
      end else if (vector_valid && load_service_level) begin
        current_service_level <= new_service_level;
      end
    end
  end
endmodule : cpu_model
`default_nettype wire

// ---- sim/piw_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module piw_chk
  import int_pkg::*;
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Register bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  // Sources and core state
  input wire logic              machine_exception_req,
  input wire logic              nonmaskable_x_request_n,
  input wire logic              ccw_i_mask,
  input wire logic              ccw_x_mask,
  input wire logic              low_power,
  input wire logic              vector_request,
  // Controller outputs
  input wire logic              maskable_to_cpu,
  input wire logic              x_to_cpu,
  input wire logic              vector_valid,
  input wire logic [ADDR_W-1:0] vector_addr,
  input wire logic              load_service_level,
  input wire logic              resume_next,
  input wire logic              wakeup
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
  vec_answer_a: assert property (vector_request |=> vector_valid)
    else $error("vector not answered next cycle");
  vec_cause_a: assert property (vector_valid |-> $past(vector_request))
    else $error("vector given without request");
  load_qual_a: assert property (
    load_service_level |-> vector_valid && !$past(ccw_i_mask))
    else $error("level loaded while masked or off fetch");
  mask_block_a: assert property ($past(ccw_i_mask) |-> !maskable_to_cpu)
    else $error("maskable request passed while masked");
  x_masked_a: assert property ($past(ccw_x_mask) |-> !x_to_cpu)
    else $error("masked x request forwarded");
  wake_idle_a: assert property (!low_power |-> !wakeup)
    else $error("wakeup outside low power");
  x_wake_a: assert property (low_power && !nonmaskable_x_request_n |-> wakeup)
    else $error("x request did not wake");
  mach_wake_a: assert property (low_power && machine_exception_req |-> wakeup)
    else $error("machine exception did not wake");
  mach_vec_a: assert property (vector_request && machine_exception_req
    |=> vector_addr[8:0] == OFS_MACHINE)
    else $error("machine vector offset wrong");
  resume_pulse_a: assert property (
    resume_next |-> ($past(low_power) && $past(ccw_x_mask)) ##1 !resume_next)
    else $error("resume pulse malformed");

  cover property (load_service_level);
  cover property (resume_next);
  cover property (low_power && wakeup);
endmodule : piw_chk

bind priority_interrupt_wakeup piw_chk chk (.pclk, .presetn, .psel, .penable, .pready,
  .machine_exception_req, .nonmaskable_x_request_n, .ccw_i_mask, .ccw_x_mask, .low_power,
  .vector_request, .maskable_to_cpu, .x_to_cpu, .vector_valid, .vector_addr,
  .load_service_level, .resume_next, .wakeup);
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import int_pkg::*;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, prdata, r;
  logic         pready, pslverr, e, mreq = 1'b0, xn = 1'b1, imask = 1'b1, xmask = 1'b1;
  logic         lp = 1'b0, fetch = 1'b0, lvl_set = 1'b0, vreq, vv, ld, m2c, x2c, rn, wk, mc;
  logic [2:0]   lvl_in = 3'h0, cur, nlvl;
  logic [23:0]  vaddr;
  logic [127:0] rq = '0;
  int           bad_count = 0, n_checks = 0, cnt, lvl[128], base = 'hfffe00;

  always #20 pclk = ~pclk;

  cpu_model cpu (.pclk, .presetn, .fetch, .lvl_set, .lvl_in, .vector_valid(vv),
    .load_service_level(ld), .new_service_level(nlvl), .vector_request(vreq),
    .current_service_level(cur));
  priority_interrupt_wakeup uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_req(rq), .machine_exception_req(mreq),
    .nonmaskable_x_request_n(xn), .ccw_i_mask(imask), .ccw_x_mask(xmask),
    .current_service_level(cur), .low_power(lp), .vector_request(vreq),
    .maskable_to_cpu(m2c), .x_to_cpu(x2c), .machine_to_cpu(mc), .vector_valid(vv),
    .vector_addr(vaddr), .load_service_level(ld), .new_service_level(nlvl),
    .resume_next(rn), .wakeup(wk));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic set_lvl(input int i, input int l);
    apb(1'b1, 8'h04, 32'(i / 8));
    apb(1'b1, 8'(8 + 4 * (i % 8)), 32'(l));
    lvl[i] = l;
  endtask : set_lvl

  task automatic setcur(input int l);
    lvl_set <= 1'b1;
    lvl_in <= 3'(l);
    @(posedge pclk);
    lvl_set <= 1'b0;
    @(posedge pclk);
  endtask : setcur

  task automatic get_vec(input int x, input logic xl);
    int n;
    n = 0;
    fetch <= 1'b1;
    @(posedge pclk);
    fetch <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (vv !== 1'b1 && n < 8);
    chk(vv, 1'b1);
    chk(vaddr, base + x);
    chk(ld, xl);
  endtask : get_vec

  // Reference winner: ascending scan with >= lets the higher index take ties
  task automatic mvec();
    int b;
    b = -1;
    // A level loaded by the previous fetch lands at this edge
    @(posedge pclk);
    for (int i = 0; i < 128; i++) begin
      if (!imask && rq[i] && lvl[i] != 0 && lvl[i] > cur && (b < 0 || lvl[i] >= lvl[b])) b = i;
    end
    if (b < 0) begin
      get_vec(OFS_SPURIOUS, 1'b0);
    end else begin
      get_vec(b * 4, 1'b1);
      chk(nlvl, lvl[b]);
    end
  endtask : mvec

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    stop_test();
  end

  initial begin
    for (int i = 0; i < 128; i++) lvl[i] = (i >= 4 && i <= 117) ? 1 : 0;
    void'($urandom(32'h7327));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'hfffe00);
    apb(1'b0, 8'h18, 32'h0);
    chk(r, 32'h1);
    apb(1'b0, 8'h2c, 32'h0);
    chk(e, 1'b1);
    $display("test reset done");
    apb(1'b1, 8'h00, 32'h123400);
    base = 'h123400;
    apb(1'b0, 8'h00, 32'h0);
    chk(r, base);
    set_lvl(117, 5);
    apb(1'b0, 8'h1c, 32'h0);
    chk(r, 32'h5);
    set_lvl(10, 3);
    set_lvl(20, 3);
    set_lvl(30, 0);
    rq <= (128'h1 << 10) | (128'h1 << 20) | (128'h1 << 30);
    imask <= 1'b0;
    @(posedge pclk);
    mvec();
    mvec();
    for (int k = 0; k < 24; k++) begin
      set_lvl($urandom_range(117, 4), $urandom_range(7, 0));
      rq <= {$urandom, $urandom, $urandom, $urandom};
      setcur($urandom_range(4, 0));
      mvec();
    end
    $display("test arbitration done");
    set_lvl(50, 2);
    rq <= 128'h1 << 50;
    imask <= 1'b1;
    lp <= 1'b1;
    setcur(0);
    repeat (2) @(posedge pclk);
    chk(wk, 1'b0);
    chk(m2c, 1'b0);
    imask <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(wk, 1'b1);
    chk(m2c, 1'b1);
    setcur(2);
    @(posedge pclk);
    chk(wk, 1'b0);
    mreq <= 1'b1;
    imask <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(wk, 1'b1);
    get_vec(OFS_MACHINE, 1'b0);
    chk(mc, 1'b1);
    mreq <= 1'b0;
    xn <= 1'b0;
    @(posedge pclk);
    chk(wk, 1'b1);
    cnt = 0;
    repeat (6) begin
      @(posedge pclk);
      cnt += int'(rn);
      chk(x2c, 1'b0);
    end
    chk(cnt, 1);
    chk(mc, 1'b0);
    xn <= 1'b1;
    lp <= 1'b0;
    @(posedge pclk);
    xmask <= 1'b0;
    xn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(x2c, 1'b1);
    get_vec(OFS_XREQ, 1'b0);
    xn <= 1'b1;
    $display("test wake done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
